//--- pkg/tsf_pkg.sv
// package: register map, field positions and reset values of the trace status block
package tsf_pkg;
  // ************************************************************
  // register indices; each register is one word, byte address is four times the index
  // ************************************************************
  localparam logic [15:0] TSF_STATUS_IDX   = 16'h301E;
  localparam logic [15:0] TSF_COUNT_IDX    = 16'h301F;
  localparam logic [15:0] TSF_CONTROL_IDX  = 16'h3020;
  localparam logic [15:0] TSF_IRQ_STAT_IDX = 16'h3021;
  localparam logic [15:0] TSF_IRQ_MASK_IDX = 16'h3022;
  // byte addresses on the apb bus
  localparam logic [15:0] TSF_STATUS_OFS   = 16'hC078;
  localparam logic [15:0] TSF_COUNT_OFS    = 16'hC07C;
  localparam logic [15:0] TSF_CONTROL_OFS  = 16'hC080;
  localparam logic [15:0] TSF_IRQ_STAT_OFS = 16'hC084;
  localparam logic [15:0] TSF_IRQ_MASK_OFS = 16'hC088;

  // ************************************************************
  // field positions
  // ************************************************************
  localparam int TSF_A_BIT      = 7;
  localparam int TSF_B_BIT      = 6;
  localparam int TSF_C_BIT      = 5;
  localparam int TSF_ARMED_FLAG_BIT   = 0;
  localparam int TSF_CTL_ARM    = 0;
  localparam int TSF_CTL_EN     = 1;
  localparam int TSF_CTL_BEGIN  = 2;
  localparam int TSF_CNT_W      = 4;
  // interrupt status bits: 0..2 match a/b/c, 3 count saturated
  localparam int TSF_IRQ_W      = 4;
  localparam int TSF_IRQ_SAT    = 3;

  // ************************************************************
  // reset values and counts
  // ************************************************************
  localparam logic [2:0] TSF_CTL_RST   = 3'h0;
  localparam logic [3:0] TSF_CNT_RST   = 4'h0;
  localparam logic [3:0] TSF_CNT_MAX   = 4'h8;

  // reset causes
  typedef enum logic [1:0] {
    TSF_RST_NONE     = 2'h0,
    TSF_RST_OTHER    = 2'h1,
    TSF_RST_END_RUN  = 2'h3,
    TSF_RST_END_TRC  = 2'h2
  } tsf_rst_kind_t;
endpackage : tsf_pkg

//--- pkg/tsf_evt_if.sv
// interface: event wires between the status core and the capture counter
`timescale 1ns/1ns
interface tsf_evt_if;
  logic       arm_rise;
  logic       capture;
  logic       enable;
  logic [3:0] count;
  logic       saturated;
  modport core (output arm_rise, output capture, output enable, input count, input saturated);
  modport cnt  (input arm_rise, input capture, input enable, output count, output saturated);
endinterface : tsf_evt_if

//--- logic/tsf_fill_counter.sv
// saturating count of words captured into the trace fifo
`timescale 1ns/1ns
module tsf_fill_counter
  import tsf_pkg::*;
#(
  parameter int DEPTH = 8
) (
  // clock and reset
  input wire logic pclk,
  input wire logic presetn,
  // soft reset clearing the count
  input wire logic clear_count,
  // event link
  tsf_evt_if.cnt   evt
);
  // the four-bit count only serves an eight-deep fifo
  if (DEPTH != 8) begin : g_bad_depth
    $error("tsf_fill_counter: depth must be 8");
  end

  logic [3:0] count;
  logic [3:0] next_count;

  always_comb begin
    next_count = count;
    if (clear_count || (evt.enable && evt.arm_rise)) begin
      next_count = TSF_CNT_RST;
    end else if (evt.enable && evt.capture && count != TSF_CNT_MAX) begin
      next_count = count + 4'h1;
    end
  end

  // no decrement path: draining the fifo leaves the count alone
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      count <= TSF_CNT_RST;
    end else begin
      count <= next_count;
    end
  end

  assign evt.count     = count;
  assign evt.saturated = (count == TSF_CNT_MAX);
endmodule : tsf_fill_counter

//--- logic/tsf_match_flags.sv
// sticky comparator match flags, cleared on arming
`timescale 1ns/1ns
module tsf_match_flags
  import tsf_pkg::*;
#(
  parameter int NCMP = 3
) (
  // clock and reset
  input  wire logic            pclk,
  input  wire logic            presetn,
  // control
  input  wire logic            clear_flags,
  input  wire logic            arm_rise,
  input  wire logic            armed,
  input  wire logic [NCMP-1:0] cmp_match,
  // state
  output logic      [NCMP-1:0] flags
);
  if (NCMP < 1) begin : g_bad_ncmp
    $error("tsf_match_flags: need at least one comparator");
  end

  logic [NCMP-1:0] next_flags;

  for (genvar i = 0; i < NCMP; i++) begin : g_flag
    always_comb begin
      next_flags[i] = flags[i];
      if (clear_flags || arm_rise) begin
        next_flags[i] = 1'b0;
      end else if (armed && cmp_match[i]) begin
        next_flags[i] = 1'b1;
      end
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      flags <= '0;
    end else begin
      flags <= next_flags;
    end
  end
endmodule : tsf_match_flags

//--- logic/tsf_trace_status.sv
// top: apb slave for trace match status, fill count, control and interrupt
//
// Decided for this implementation: the APB slave port.
`timescale 1ns/1ns

// What this block does
// - comparator a hit sets sticky flag until rearm
// - comparator b hit since arming sets flag
// - comparator c hit since arming sets flag
// - reserved status and count bits read zero
// - armed flag mirrors arm bit while enabled
// - armed flag high from arming until run end or reset, storing after a begin trigger included, else zero
// - end-run reset clears armed flag
// - end-trace reset in enabled end mode keeps match flags, clears armed
// - power-on and ordinary resets clear count
// - end-trace reset in enabled end mode keeps the valid count
// - count saturates at eight
// - arming clears count, each capture increments
// - fifo reads never decrement the count
// - begin bit selects start or end storing
// - enable gates arming, triggering and storing
module tsf_trace_status
  import tsf_pkg::*;
(
  // clock and reset
  input  wire logic        pclk,
  input  wire logic        presetn,
  // apb slave
  input  wire logic        psel,
  input  wire logic        penable,
  input  wire logic        pwrite,
  input  wire logic [15:0] paddr,
  input  wire logic [31:0] pwdata,
  output logic      [31:0] prdata,
  output logic             pready,
  output logic             pslverr,
  // comparator and capture side
  input  wire logic [2:0]  cmp_match,
  input  wire logic        trigger_hit,
  input  wire logic        fifo_capture,
  input  wire logic        fifo_full,
  // soft reset causes, one-cycle pulses
  input  wire logic [1:0]  soft_reset_kind,
  // to capture logic
  output logic             store_enable,
  output logic             irq
);
  // ************************************************************
  // control register
  // ************************************************************
  logic       arm;
  logic       trace_unit_enable;
  logic       begin_mode;
  logic [2:0] next_ctl;
  logic       armed_q;
  logic       triggered;
  logic       next_triggered;
  logic       arm_rise;
  logic       armed_flag;

  tsf_rst_kind_t rkind;
  logic          keep_state;
  logic          clr_flags;
  logic          clr_count;

  logic [2:0]    flags;
  tsf_evt_if     evt ();

  logic [TSF_IRQ_W-1:0] irq_stat;
  logic [TSF_IRQ_W-1:0] irq_mask;
  logic [TSF_IRQ_W-1:0] next_irq_stat;
  logic [TSF_IRQ_W-1:0] next_irq_mask;
  logic [TSF_IRQ_W-1:0] irq_evt;
  logic                 sat_q;

  logic        wr_en;
  logic        rd_en;
  logic        hit;
  logic [31:0] rdata;
  logic [31:0] next_prdata;
  logic        next_pready;
  logic        next_pslverr;
  logic        next_store;
  logic        next_irq;

  assign rkind      = tsf_rst_kind_t'(soft_reset_kind);
  // end-trace reset only preserves state in enabled end-trigger mode
  assign keep_state = (rkind == TSF_RST_END_TRC) && trace_unit_enable && !begin_mode;
  assign clr_flags  = (rkind == TSF_RST_OTHER) || (rkind == TSF_RST_END_RUN)
                    || ((rkind == TSF_RST_END_TRC) && !keep_state);
  assign clr_count  = (rkind == TSF_RST_OTHER) || (rkind == TSF_RST_END_RUN)
                    || ((rkind == TSF_RST_END_TRC) && !keep_state);

  // a write lands at the edge where the master sees pready high
  assign wr_en = psel && penable && pwrite && pready;
  assign rd_en = psel && penable && !pwrite && !pready;

  always_comb begin
    next_ctl = {begin_mode, trace_unit_enable, arm};
    if (wr_en && paddr == TSF_CONTROL_OFS) begin
      next_ctl = pwdata[2:0];
      // arming is only possible while enabled
      next_ctl[TSF_CTL_ARM] = pwdata[TSF_CTL_ARM] && pwdata[TSF_CTL_EN];
    end
    // run end: trigger seen in end mode, or fifo full after begin trigger
    if (arm && triggered && (!begin_mode || fifo_full)) begin
      next_ctl[TSF_CTL_ARM] = 1'b0;
    end
    if (rkind != TSF_RST_NONE) begin
      next_ctl[TSF_CTL_ARM] = 1'b0;
      if (!keep_state) begin
        next_ctl = TSF_CTL_RST;
      end
    end
  end

  always_comb begin
    next_triggered = triggered;
    if (arm_rise || !arm) begin
      next_triggered = 1'b0;
    end else if (trace_unit_enable && trigger_hit) begin
      next_triggered = 1'b1;
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      {begin_mode, trace_unit_enable, arm} <= TSF_CTL_RST;
      armed_q   <= 1'b0;
      triggered <= 1'b0;
    end else begin
      {begin_mode, trace_unit_enable, arm} <= next_ctl;
      armed_q   <= arm;
      triggered <= next_triggered;
    end
  end

  assign arm_rise   = arm && !armed_q;
  assign armed_flag = arm && trace_unit_enable;

  // ************************************************************
  // match flags and fill counter
  // ************************************************************
  tsf_match_flags #(.NCMP(3)) u_flags (
    .pclk        (pclk),
    .presetn     (presetn),
    .clear_flags (clr_flags),
    .arm_rise    (arm_rise),
    .armed       (armed_flag),
    .cmp_match   (cmp_match),
    .flags       (flags)
  );

  // storing window: after trigger in begin mode, until trigger in end mode
  assign evt.arm_rise = arm_rise;
  assign evt.enable   = trace_unit_enable;
  assign evt.capture  = fifo_capture && armed_flag && (begin_mode ? triggered : !triggered);

  tsf_fill_counter #(.DEPTH(8)) u_count (
    .pclk        (pclk),
    .presetn     (presetn),
    .clear_count (clr_count),
    .evt         (evt)
  );

  // ************************************************************
  // interrupt status, write one to clear
  // ************************************************************
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      sat_q <= 1'b0;
    end else begin
      sat_q <= evt.saturated;
    end
  end

  assign irq_evt = {evt.saturated && !sat_q, armed_flag ? cmp_match : 3'h0};

  always_comb begin
    next_irq_stat = irq_stat;
    next_irq_mask = irq_mask;
    if (wr_en && paddr == TSF_IRQ_STAT_OFS) begin
      next_irq_stat = irq_stat & ~pwdata[TSF_IRQ_W-1:0];
    end
    if (wr_en && paddr == TSF_IRQ_MASK_OFS) begin
      next_irq_mask = pwdata[TSF_IRQ_W-1:0];
    end
    // a new event wins over a simultaneous clear
    next_irq_stat = next_irq_stat | irq_evt;
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      irq_stat <= '0;
      irq_mask <= '0;
    end else begin
      irq_stat <= next_irq_stat;
      irq_mask <= next_irq_mask;
    end
  end

  // ************************************************************
  // apb read mux and outputs
  // ************************************************************
  always_comb begin
    rdata = 32'h0;
    hit   = 1'b1;
    unique case (paddr)
      // writes here fall through with no effect
      TSF_STATUS_OFS: begin
        rdata[TSF_A_BIT]    = flags[0];
        rdata[TSF_B_BIT]    = flags[1];
        rdata[TSF_C_BIT]    = flags[2];
        rdata[TSF_ARMED_FLAG_BIT] = armed_flag;
      end
      TSF_COUNT_OFS: begin
        rdata[TSF_CNT_W-1:0] = evt.count;
      end
      TSF_CONTROL_OFS:  rdata[2:0] = {begin_mode, trace_unit_enable, arm};
      TSF_IRQ_STAT_OFS: rdata[TSF_IRQ_W-1:0] = irq_stat;
      TSF_IRQ_MASK_OFS: rdata[TSF_IRQ_W-1:0] = irq_mask;
      default:          hit = 1'b0;
    endcase
  end

  always_comb begin
    next_pready  = psel && penable && !pready;
    next_pslverr = psel && penable && !pready && !hit;
    next_prdata  = rd_en ? rdata : prdata;
    next_store   = armed_flag && (begin_mode ? triggered : !triggered);
    next_irq     = |(next_irq_stat & next_irq_mask);
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      prdata       <= 32'h0;
      pready       <= 1'b0;
      pslverr      <= 1'b0;
      store_enable <= 1'b0;
      irq          <= 1'b0;
    end else begin
      prdata       <= next_prdata;
      pready       <= next_pready;
      pslverr      <= next_pslverr;
      store_enable <= next_store;
      irq          <= next_irq;
    end
  end
endmodule : tsf_trace_status

//--- sim/tsf_trace_status_props.sv
// checker: bus timing and read values of the trace status top
`timescale 1ns/1ns
module tsf_trace_status_props
  import tsf_pkg::*;
(
  // clock and reset
  input wire logic        pclk,
  input wire logic        presetn,
  // apb
  input wire logic        psel,
  input wire logic        penable,
  input wire logic        pwrite,
  input wire logic [15:0] paddr,
  input wire logic [31:0] prdata,
  input wire logic        pready,
  input wire logic        pslverr,
  // events
  input wire logic [1:0]  soft_reset_kind,
  input wire logic        store_enable
);
  // ****
  // properties
  // ****
  default clocking @(posedge pclk); endclocking
  default disable iff (!presetn);
  sequence s_access;
    psel && penable && !pready;
  endsequence
  sequence s_rd(logic [15:0] a);
    pready && !pwrite && paddr == a;
  endsequence
  a_answer_next: assert property (s_access |=> pready) else $error("no answer");
  a_ready_pulse: assert property (pready |=> !pready) else $error("pready too long");
  a_ready_access: assert property (pready |-> psel && penable) else $error("stray pready");
  a_idle_quiet: assert property (!psel |=> !pready && !pslverr) else $error("idle answer");
  a_err_zero: assert property (pslverr |-> pready && prdata == 32'h0) else $error("bad error");
  a_status_rsvd: assert property (s_rd(TSF_STATUS_OFS) |->
    prdata[31:8] == 24'h0 && prdata[4:1] == 4'h0) else $error("status reserved");
  a_count_range: assert property (s_rd(TSF_COUNT_OFS) |->
    prdata[31:4] == 28'h0 && prdata[3:0] <= TSF_CNT_MAX) else $error("count range");
  a_reset_closes: assert property (soft_reset_kind != TSF_RST_NONE |->
    ##[1:3] !store_enable) else $error("window open");
endmodule : tsf_trace_status_props

bind tsf_trace_status tsf_trace_status_props i_props (.pclk, .presetn, .psel, .penable,
  .pwrite, .paddr, .prdata, .pready, .pslverr, .soft_reset_kind, .store_enable);

//--- sim/tsf_capture_model.sv
// model: comparators and fifo capture strobes
`timescale 1ns/1ns
module tsf_capture_model (
  // clock and reset
  input  wire logic       pclk,
  input  wire logic       presetn,
  // bench commands
  input  wire logic [2:0] cmp_set,
  input  wire logic       trig,
  input  wire logic       go,
  input  wire logic       slow,
  input  wire logic [4:0] req_words,
  // to the block
  output logic      [2:0] cmp_match,
  output logic            trigger_hit,
  output logic            fifo_capture,
  output logic            fifo_full,
  output logic            busy
);
  // ****
  // capture engine
  // ****
  logic [4:0] left;
  logic [4:0] total;
  logic       ph;
  assign busy = left != 5'h0;
  assign fifo_full = total >= 5'h8;
  // slow mode stores every other cycle
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      {left, total, ph, cmp_match, trigger_hit, fifo_capture} <= '0;
    end else begin
      cmp_match    <= cmp_set;
      trigger_hit  <= trig;
      ph           <= !ph;
      fifo_capture <= 1'h0;
      if (go) begin
        left  <= req_words;
        total <= 5'h0;
      end else if (busy && (!slow || ph)) begin
        left         <= left - 5'h1;
        total        <= total + 5'h1;
        fifo_capture <= 1'h1;
      end
    end
  end
endmodule : tsf_capture_model

//--- sim/tb_top.sv
// testbench: register reads, capture runs and soft resets
`timescale 1ns/1ns
module tb_top;
  import tsf_pkg::*;
  // ****
  // signals
  // ****
  logic        pclk = 1'h0, presetn = 1'h0, psel = 1'h0, penable = 1'h0, pwrite = 1'h0;
  logic [15:0] paddr = 16'h0;
  logic [31:0] pwdata = 32'h0, prdata, rdat;
  logic        pready, pslverr, err, trig = 1'h0, go = 1'h0, slow = 1'h0;
  logic [2:0]  cmp_set = 3'h0, cmp_match;
  logic [4:0]  req_words = 5'h0;
  logic [1:0]  soft_reset_kind = 2'h0;
  logic        trigger_hit, fifo_capture, fifo_full, busy, store_enable, irq;
  int          mismatches = 0, n_checks = 0, cyc = 0;
  always #4 pclk = ~pclk;
  tsf_trace_status i_dut (.pclk, .presetn, .psel, .penable, .pwrite, .paddr, .pwdata,
    .prdata, .pready, .pslverr, .cmp_match, .trigger_hit, .fifo_capture, .fifo_full,
    .soft_reset_kind, .store_enable, .irq);
  tsf_capture_model i_cap (.pclk, .presetn, .cmp_set, .trig, .go, .slow, .req_words,
    .cmp_match, .trigger_hit, .fifo_capture, .fifo_full, .busy);
  task automatic give_verdict();
    if (mismatches == 0 && n_checks > 0) begin
      $display("STATUS OK");
    end else begin
      $display("STATUS NOT OK");
    end
    $finish;
  endtask : give_verdict
  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    n_checks++;
    if (got !== exp) begin
      mismatches++;
      $display("Error %0t: saw %h expected %h", $time, got, exp);
    end
  endtask : chk
  // request held until pready is seen high at an edge
  task automatic apb(input logic w, input logic [15:0] a, input logic [31:0] d);
    @(posedge pclk);
    psel   <= 1'h1;
    pwrite <= w;
    paddr  <= a;
    pwdata <= d;
    @(posedge pclk);
    penable <= 1'h1;
    @(posedge pclk);
    while (pready !== 1'h1) @(posedge pclk);
    rdat = prdata;
    err  = pslverr;
    psel    <= 1'h0;
    penable <= 1'h0;
  endtask : apb
  task automatic rc(input logic [15:0] a, input logic [31:0] exp);
    apb(1'h0, a, 32'h0);
    chk(rdat, exp);
  endtask : rc
  task automatic wr(input logic [15:0] a, input logic [31:0] d);
    apb(1'h1, a, d);
    repeat (2) @(posedge pclk);
  endtask : wr
  task automatic ev(input logic [2:0] c, input logic t, input logic [1:0] k);
    @(posedge pclk);
    cmp_set         <= c;
    trig            <= t;
    soft_reset_kind <= k;
    @(posedge pclk);
    cmp_set         <= 3'h0;
    trig            <= 1'h0;
    soft_reset_kind <= TSF_RST_NONE;
    repeat (3) @(posedge pclk);
  endtask : ev
  task automatic cap(input logic [4:0] n, input logic s);
    @(posedge pclk);
    req_words <= n;
    slow      <= s;
    go        <= 1'h1;
    @(posedge pclk);
    go <= 1'h0;
    @(posedge pclk);
    while (busy !== 1'h0) @(posedge pclk);
    repeat (2) @(posedge pclk);
  endtask : cap
  always @(posedge pclk) begin
    cyc++;
    if (cyc == 3000) begin
      mismatches++;
      give_verdict();
    end
  end
  initial begin
    repeat (6) @(posedge pclk);
    presetn <= 1'h1;
    wr(TSF_STATUS_OFS, 32'hFF);
    wr(TSF_COUNT_OFS, 32'hFF);
    rc(TSF_STATUS_OFS, 32'h0);
    rc(TSF_COUNT_OFS, 32'h0);
    apb(1'h0, 16'h3000, 32'h0);
    chk({31'h0, err}, 32'h1);
    wr(TSF_CONTROL_OFS, 32'h2);
    wr(TSF_CONTROL_OFS, 32'h3);
    rc(TSF_STATUS_OFS, 32'h01);
    ev(3'h5, 1'h0, TSF_RST_NONE);
    rc(TSF_STATUS_OFS, 32'hA1);
    ev(3'h2, 1'h0, TSF_RST_NONE);
    rc(TSF_STATUS_OFS, 32'hE1);
    chk({31'h0, irq}, 32'h0);
    wr(TSF_IRQ_MASK_OFS, 32'h7);
    chk({31'h0, irq}, 32'h1);
    wr(TSF_IRQ_STAT_OFS, 32'h7);
    chk({31'h0, irq}, 32'h0);
    cap(5'hA, 1'h1);
    rc(TSF_COUNT_OFS, 32'h8);
    ev(3'h0, 1'h1, TSF_RST_NONE);
    rc(TSF_STATUS_OFS, 32'hE0);
    ev(3'h0, 1'h0, TSF_RST_END_TRC);
    rc(TSF_STATUS_OFS, 32'hE0);
    rc(TSF_COUNT_OFS, 32'h8);
    wr(TSF_CONTROL_OFS, 32'h3);
    rc(TSF_STATUS_OFS, 32'h01);
    cap(5'h3, 1'h0);
    rc(TSF_COUNT_OFS, 32'h3);
    ev(3'h0, 1'h0, TSF_RST_END_RUN);
    rc(TSF_STATUS_OFS, 32'h0);
    wr(TSF_CONTROL_OFS, 32'h2);
    wr(TSF_CONTROL_OFS, 32'h3);
    cap(5'h2, 1'h0);
    ev(3'h0, 1'h0, TSF_RST_OTHER);
    rc(TSF_COUNT_OFS, 32'h0);
    wr(TSF_CONTROL_OFS, 32'h1);
    cap(5'h2, 1'h0);
    rc(TSF_STATUS_OFS, 32'h0);
    rc(TSF_COUNT_OFS, 32'h0);
    wr(TSF_CONTROL_OFS, 32'h6);
    wr(TSF_CONTROL_OFS, 32'h7);
    cap(5'h2, 1'h0);
    rc(TSF_COUNT_OFS, 32'h0);
    ev(3'h0, 1'h1, TSF_RST_NONE);
    cap(5'h3, 1'h0);
    rc(TSF_COUNT_OFS, 32'h3);
    give_verdict();
  end
endmodule : tb_top
